/* core/synth_cfg_pkg.sv */
package synth_cfg_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address = 4 * index)
    // ------------------------------------------------------------
    localparam logic [5:0]  IDX_CAL_CTRL      = 6'h00;
    localparam logic [5:0]  IDX_CAL_CLK_DIV   = 6'h01;
    localparam logic [5:0]  IDX_AMP_CAL_DELAY = 6'h04;
    localparam logic [5:0]  IDX_FORCE_CTRL    = 6'h08;
    localparam logic [5:0]  IDX_REF_DOUBLER   = 6'h09;
    localparam logic [5:0]  IDX_REF_REF_MULTIPLIER_SEL      = 6'h0a;
    localparam logic [5:0]  IDX_REF_POST_DIV  = 6'h0b;
    localparam logic [5:0]  IDX_REF_PRE_DIV   = 6'h0c;
    localparam logic [5:0]  IDX_PUMP_CURRENT  = 6'h0e;
    localparam logic [5:0]  IDX_FORCED_AMP    = 6'h10;
    localparam logic [5:0]  IDX_START_AMP     = 6'h11;
    localparam logic [5:0]  IDX_FORCED_BAND   = 6'h13;
    localparam logic [5:0]  IDX_CORE_SELECT   = 6'h14;
    localparam logic [5:0]  IDX_CAL_STATUS    = 6'h15;
    localparam logic [5:0]  IDX_CAL_RESULT    = 6'h16;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int          POS_CAL_TRIGGER   = 3;
    localparam int          POS_DOUBLER       = 12;
    localparam int          POS_REF_MULTIPLIER_SEL_LO       = 7;
    localparam int          POS_POST_LO       = 4;
    localparam int          POS_PUMP_LO       = 4;
    localparam int          POS_DELAY_LO      = 8;
    localparam int          POS_AMP_FORCE     = 14;
    localparam int          POS_BAND_FORCE    = 11;
    localparam int          POS_CORE_LO       = 11;
    localparam int          POS_CORE_FORCE    = 10;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [2:0]  RST_CAL_CLK_DIV   = 3'h3;
    localparam logic [7:0]  RST_AMP_DELAY     = 8'h0a;
    localparam logic [4:0]  RST_REF_MULTIPLIER_SEL          = 5'h01;
    localparam logic [7:0]  RST_POST_DIV      = 8'h01;
    localparam logic [11:0] RST_PRE_DIV       = 12'h001;
    localparam logic [2:0]  RST_PUMP          = 3'h7;
    localparam logic [8:0]  RST_FORCED_AMP    = 9'h080;
    localparam logic [8:0]  RST_START_AMP     = 9'h0fa;
    localparam logic [7:0]  RST_FORCED_BAND   = 8'hb7;
    localparam logic [2:0]  RST_CORE          = 3'h7;

    // ------------------------------------------------------------
    // Codes and timing
    // ------------------------------------------------------------
    localparam logic [4:0]  REF_MULTIPLIER_SEL_BYPASS       = 5'h01;
    localparam logic [4:0]  REF_MULTIPLIER_SEL_X3           = 5'h03;
    localparam logic [4:0]  REF_MULTIPLIER_SEL_X7           = 5'h07;
    localparam logic [2:0]  REF_MULTIPLIER_SEL_FACTOR_1     = 3'h1;
    localparam logic [2:0]  REF_MULTIPLIER_SEL_FACTOR_3     = 3'h3;
    localparam logic [2:0]  REF_MULTIPLIER_SEL_FACTOR_7     = 3'h7;
    localparam int          AMP_STEPS         = 4;

    typedef enum logic [1:0] {CAL_IDLE, CAL_AMP, CAL_DONE} cal_state_t;

endpackage

/* core/cal_engine.sv */
`timescale 1ns/1ps
module cal_engine
    import synth_cfg_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       start,
    input  wire logic [2:0] clk_div_code,
    input  wire logic [7:0] amp_delay,
    input  wire logic [8:0] start_amp,
    input  wire logic       amp_force,
    input  wire logic [8:0] forced_amp,
    input  wire logic       band_force,
    input  wire logic [7:0] forced_band,
    input  wire logic       core_force,
    input  wire logic [2:0] core_sel,
    output logic            busy,
    output logic            done,
    output logic [8:0]      amp_q,
    output logic [7:0]      band_q,
    output logic [2:0]      core_q
);
    // ------------------------------------------------------------
    // Calibration tick: reference divided by 1, 2, 4 or 8
    // ------------------------------------------------------------
    cal_state_t  state_q;
    logic [2:0]  div_cnt_q;
    logic [7:0]  dly_cnt_q;
    logic [2:0]  step_q;
    logic [2:0]  div_mask;
    wire         tick;
    wire  [1:0]  div_code;

    // Codes above 3 saturate at divide by 8
    assign div_code = (clk_div_code > 3'h3) ? 2'h3 : clk_div_code[1:0];
    assign div_mask = 3'((4'h1 << div_code) - 4'h1);           // R14
    assign tick     = ((div_cnt_q & div_mask) == div_mask);    // R14
    assign busy     = (state_q != CAL_IDLE);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            div_cnt_q <= 3'h0;
        end else begin
            div_cnt_q <= div_cnt_q + 3'h1;
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q   <= CAL_IDLE;
            dly_cnt_q <= 8'h00;
            step_q    <= 3'h0;
            done      <= 1'b0;
            amp_q     <= RST_START_AMP;
            band_q    <= RST_FORCED_BAND;
            core_q    <= RST_CORE;
        end else begin
            case (state_q)
                CAL_IDLE: begin
                    // Done is a one-cycle pulse, so that a later trigger can clear the sticky flag
                    done <= 1'b0;
                    if (start) begin                            // R15
                        state_q   <= CAL_AMP;
                        dly_cnt_q <= amp_delay;
                        step_q    <= 3'h0;
                        amp_q     <= amp_force ? forced_amp : start_amp; // R9 R10
                        core_q    <= core_sel;                   // R12 R13
                        if (band_force) begin
                            band_q <= forced_band;               // R11
                        end
                    end
                end
                CAL_AMP: begin
                    if (tick) begin
                        if (dly_cnt_q != 8'h00) begin
                            dly_cnt_q <= dly_cnt_q - 8'h01;
                        end else if (amp_force || step_q == 3'(AMP_STEPS)) begin
                            state_q <= CAL_DONE;                 // R9
                        end else begin
                            // Search walks amplitude down from start point
                            amp_q     <= amp_q - 9'h001;
                            step_q    <= step_q + 3'h1;
                            dly_cnt_q <= amp_delay;
                            if (!core_force && !band_force) begin
                                band_q <= band_q + 8'h01;
                            end
                        end
                    end
                end
                CAL_DONE: begin
                    done    <= 1'b1;
                    state_q <= CAL_IDLE;
                end
                default: begin
                    state_q <= CAL_IDLE;
                end
            endcase
        end
    end

    force_amp_a: assert property (@(posedge sys_clk) disable iff (rst)
        (state_q == CAL_IDLE && start && amp_force) |=> amp_q == $past(forced_amp)) // R9
        else $error("forced amplitude not loaded");
    start_amp_a: assert property (@(posedge sys_clk) disable iff (rst)
        (state_q == CAL_IDLE && start && !amp_force) |=> amp_q == $past(start_amp)) // R10
        else $error("start amplitude not loaded");
    force_band_a: assert property (@(posedge sys_clk) disable iff (rst)
        (state_q == CAL_IDLE && start && band_force) |=> band_q == $past(forced_band)) // R11
        else $error("forced band not loaded");
    core_load_a: assert property (@(posedge sys_clk) disable iff (rst)
        (state_q == CAL_IDLE && start) |=> core_q == $past(core_sel)) // R12
        else $error("core select not loaded");
    core_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
        (busy && core_force) |=> $stable(core_q)) // R13
        else $error("forced core changed");
    tick_rate_a: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_div_code == 3'h3 && tick) |=> !tick [*7]) // R14
        else $error("calibration tick too fast");
endmodule

/* core/synth_cfg_regs.sv */
`timescale 1ns/1ps
// Notes on behaviour
// (R1) The reference doubler is enabled by its bit and bypassed when clear; reset 0.
// (R2) The multiplier field selects bypass for 1, x3 for 3, x7 for 7, other codes reserved; reset 1.
// (R3) The 8-bit post-divider after the multiplier divides by its value; reset 1.
// (R4) The 12-bit pre-divider before the multiplier divides by its value; reset 1.
// (R5) The pump current field decodes 0:0, 1:6, 3:12, 4:3, 5:9, 7:15 mA, 2 and 6 reserved; reset 7.
// (R6) Software never sets the amplitude calibration delay below 10, its reset value.
// (R7) Software sets that delay above the calibration clock rate over 10 MHz for best noise.
// (R8) Software sets that delay to 25 or more when calibration time matters.
// (R9) With amplitude force set the forced amplitude is the final amplitude; resets 128 and 0.
// (R10) The amplitude search starts at the start amplitude field; reset 250.
// (R11) With band force set the forced band is the final band; resets 183 and 0.
// (R12) The core field names the start core and the forced core, 1 to 7; reset 7.
// (R13) With core force set the selected core is held; reset 0, for diagnostics.
// (R14) The calibration clock divides the reference by 1, 2, 4 or 8 for codes 0 to 3; reset 3.
// (R15) Writing 1 to the calibration trigger bit starts a calibration with the current settings.
// (R16) Software writes the fixed pattern into bits outside the named fields.
// (R17) Registers are 16 bits, a write updates all fields at once, all fields reset.
module synth_cfg_regs
    import synth_cfg_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    output logic             ref_doubler_en,
    output logic [2:0]       ref_ref_multiplier_sel_factor,
    output logic             ref_ref_multiplier_sel_valid,
    output logic [7:0]       ref_post_div,
    output logic [11:0]      ref_pre_div,
    output logic [3:0]       pump_current_ma,
    output logic             pump_current_valid,
    output logic             cal_busy,
    output logic [8:0]       vco_amp,
    output logic [7:0]       vco_band,
    output logic [2:0]       vco_core
);
    import synth_cfg_pkg::*;

    // ------------------------------------------------------------
    // Field storage
    // ------------------------------------------------------------
    logic [2:0]  cal_clk_div_q;
    logic [7:0]  amp_cal_delay_q;
    logic        amp_force_en_q;
    logic        band_force_en_q;
    logic        doubler_q;
    logic [4:0]  ref_multiplier_sel_q;
    logic [7:0]  post_q;
    logic [11:0] pre_q;
    logic [2:0]  pump_q;
    logic [8:0]  forced_amplitude_q;
    logic [8:0]  start_amplitude_q;
    logic [7:0]  forced_band_q;
    logic [2:0]  core_q;
    logic        core_force_q;
    logic        trigger_q;
    logic        ack_q;
    logic        err_q;
    logic [31:0] rdata_q;
    logic        cal_done;
    logic        done_sticky_q;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire         req      = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
    wire  [5:0]  idx      = wb_adr_i[7:2];
    wire         aligned  = (wb_adr_i[1:0] == 2'b00);
    // Only the low half-word carries data; both lanes must be enabled to write
    wire         lanes_ok = (wb_sel_i[1:0] == 2'b11);
    wire  [15:0] wd       = wb_dat_i[15:0];

    logic        mapped;
    logic [15:0] rd;
    always_comb begin
        mapped = 1'b1;
        rd     = 16'h0000;
        // Fixed bit patterns read back as software must write them
        case (idx)
            IDX_CAL_CTRL:      rd = 16'h0000;
            IDX_CAL_CLK_DIV:   rd = {13'h0001, cal_clk_div_q};
            IDX_AMP_CAL_DELAY: rd = {amp_cal_delay_q, 8'h43};
            IDX_FORCE_CTRL:    rd = {1'b0, amp_force_en_q, 2'b10, band_force_en_q, 11'h000};
            IDX_REF_DOUBLER:   rd = {3'h0, doubler_q, 12'h604};
            IDX_REF_REF_MULTIPLIER_SEL:      rd = {4'h1, ref_multiplier_sel_q, 7'h58};
            IDX_REF_POST_DIV:  rd = {4'h0, post_q, 4'h8};
            IDX_REF_PRE_DIV:   rd = {4'h5, pre_q};
            IDX_PUMP_CURRENT:  rd = {9'h03c, pump_q, 4'h0};
            IDX_FORCED_AMP:    rd = {7'h00, forced_amplitude_q};
            IDX_START_AMP:     rd = {7'h00, start_amplitude_q};
            IDX_FORCED_BAND:   rd = {8'h27, forced_band_q};
            IDX_CORE_SELECT:   rd = {2'b11, core_q, core_force_q, 10'h048};
            IDX_CAL_STATUS:    rd = {14'h0000, done_sticky_q, cal_busy};
            IDX_CAL_RESULT:    rd = {core_q == 3'h0 ? 3'h0 : vco_core, vco_band, 5'h00};
            default:           mapped = 1'b0;
        endcase
    end

    wire ok   = mapped && aligned && (lanes_ok || !wb_we_i);
    wire wr   = req && ok && wb_we_i;
    wire wr_at_0 = wr && (idx == IDX_CAL_CTRL);

    assign wb_ack_o = ack_q;
    assign wb_err_o = err_q;
    assign wb_dat_o = rdata_q;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ack_q   <= 1'b0;
            err_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q   <= req && ok;
            err_q   <= req && !ok;
            rdata_q <= (req && ok) ? {16'h0000, rd} : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Register writes: whole register at once
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin                                              // R17
            cal_clk_div_q      <= RST_CAL_CLK_DIV;                   // R14
            amp_cal_delay_q    <= RST_AMP_DELAY;
            amp_force_en_q     <= 1'b0;
            band_force_en_q    <= 1'b0;
            doubler_q          <= 1'b0;                              // R1
            ref_multiplier_sel_q             <= RST_REF_MULTIPLIER_SEL;                          // R2
            post_q             <= RST_POST_DIV;                      // R3
            pre_q              <= RST_PRE_DIV;                       // R4
            pump_q             <= RST_PUMP;                          // R5
            forced_amplitude_q <= RST_FORCED_AMP;                    // R9
            start_amplitude_q  <= RST_START_AMP;                     // R10
            forced_band_q      <= RST_FORCED_BAND;                   // R11
            core_q             <= RST_CORE;                          // R12
            core_force_q       <= 1'b0;                              // R13
        end else if (wr) begin                                      // R17
            case (idx)
                IDX_CAL_CLK_DIV:   cal_clk_div_q      <= wd[2:0];
                IDX_AMP_CAL_DELAY: amp_cal_delay_q    <= wd[POS_DELAY_LO +: 8];
                IDX_FORCE_CTRL: begin
                    amp_force_en_q  <= wd[POS_AMP_FORCE];
                    band_force_en_q <= wd[POS_BAND_FORCE];
                end
                IDX_REF_DOUBLER:   doubler_q          <= wd[POS_DOUBLER];
                IDX_REF_REF_MULTIPLIER_SEL:      ref_multiplier_sel_q             <= wd[POS_REF_MULTIPLIER_SEL_LO +: 5];
                IDX_REF_POST_DIV:  post_q             <= wd[POS_POST_LO +: 8];
                IDX_REF_PRE_DIV:   pre_q              <= wd[11:0];
                IDX_PUMP_CURRENT:  pump_q             <= wd[POS_PUMP_LO +: 3];
                IDX_FORCED_AMP:    forced_amplitude_q <= wd[8:0];
                IDX_START_AMP:     start_amplitude_q  <= wd[8:0];
                IDX_FORCED_BAND:   forced_band_q      <= wd[7:0];
                IDX_CORE_SELECT: begin
                    core_q       <= wd[POS_CORE_LO +: 3];
                    core_force_q <= wd[POS_CORE_FORCE];
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Calibration trigger and sticky done
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            trigger_q     <= 1'b0;
            done_sticky_q <= 1'b0;
        end else begin
            trigger_q <= wr_at_0 && wd[POS_CAL_TRIGGER];            // R15
            // A new trigger clears done; a finishing calibration wins
            if (cal_done) begin
                done_sticky_q <= 1'b1;
            end else if (trigger_q) begin
                done_sticky_q <= 1'b0;
            end
        end
    end

    cal_engine u_cal (
        .sys_clk      (sys_clk),
        .rst          (rst),
        .start        (trigger_q),
        .clk_div_code (cal_clk_div_q),
        .amp_delay    (amp_cal_delay_q),
        .start_amp    (start_amplitude_q),
        .amp_force    (amp_force_en_q),
        .forced_amp   (forced_amplitude_q),
        .band_force   (band_force_en_q),
        .forced_band  (forced_band_q),
        .core_force   (core_force_q),
        .core_sel     (core_q),
        .busy         (cal_busy),
        .done         (cal_done),
        .amp_q        (vco_amp),
        .band_q       (vco_band),
        .core_q       (vco_core)
    );

    // ------------------------------------------------------------
    // Analog-facing decodes
    // ------------------------------------------------------------
    assign ref_doubler_en = doubler_q;                              // R1
    assign ref_post_div   = post_q;                                 // R3
    assign ref_pre_div    = pre_q;                                  // R4

    always_comb begin
        ref_ref_multiplier_sel_valid  = 1'b1;
        ref_ref_multiplier_sel_factor = REF_MULTIPLIER_SEL_FACTOR_1;
        case (ref_multiplier_sel_q)                                               // R2
            REF_MULTIPLIER_SEL_BYPASS: ref_ref_multiplier_sel_factor = REF_MULTIPLIER_SEL_FACTOR_1;
            REF_MULTIPLIER_SEL_X3:     ref_ref_multiplier_sel_factor = REF_MULTIPLIER_SEL_FACTOR_3;
            REF_MULTIPLIER_SEL_X7:     ref_ref_multiplier_sel_factor = REF_MULTIPLIER_SEL_FACTOR_7;
            default:     ref_ref_multiplier_sel_valid  = 1'b0;
        endcase
    end

    always_comb begin
        pump_current_valid = 1'b1;
        pump_current_ma    = 4'h0;
        case (pump_q)                                               // R5
            3'h0:    pump_current_ma = 4'h0;
            3'h1:    pump_current_ma = 4'h6;
            3'h3:    pump_current_ma = 4'hc;
            3'h4:    pump_current_ma = 4'h3;
            3'h5:    pump_current_ma = 4'h9;
            3'h7:    pump_current_ma = 4'hf;
            default: pump_current_valid = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    ack_one_a: assert property (@(posedge sys_clk) disable iff (rst)
        wb_ack_o |=> !wb_ack_o) // R17
        else $error("ack held longer than one cycle");
    trigger_start_a: assert property (@(posedge sys_clk) disable iff (rst)
        (wr_at_0 && wd[POS_CAL_TRIGGER] && !cal_busy) |=> ##1 cal_busy) // R15
        else $error("trigger did not start calibration");
    pump_decode_a: assert property (@(posedge sys_clk) disable iff (rst)
        (pump_q == 3'h3) |-> (pump_current_ma == 4'hc && pump_current_valid)) // R5
        else $error("pump current decode wrong");
    ref_multiplier_sel_decode_a: assert property (@(posedge sys_clk) disable iff (rst)
        (ref_multiplier_sel_q == 5'h02) |-> !ref_ref_multiplier_sel_valid) // R2
        else $error("reserved multiplier accepted");
    doubler_write_a: assert property (@(posedge sys_clk) disable iff (rst)
        (wr && idx == IDX_REF_DOUBLER) |=> ref_doubler_en == $past(wd[POS_DOUBLER])) // R1
        else $error("doubler bit not written");
    pre_div_write_a: assert property (@(posedge sys_clk) disable iff (rst)
        (wr && idx == IDX_REF_PRE_DIV) |=> ref_pre_div == $past(wd[11:0])) // R4
        else $error("pre-divider not written");
    post_div_write_a: assert property (@(posedge sys_clk) disable iff (rst)
        (wr && idx == IDX_REF_POST_DIV) |=> ref_post_div == $past(wd[11:4])) // R3
        else $error("post-divider not written");
endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    import synth_cfg_pkg::*;
    // ------------------------------------------------------------
    // Register table: index, writable mask, fixed pattern, reset
    // ------------------------------------------------------------
    localparam logic [5:0]  RIDX [11] = '{6'h04, 6'h08, 6'h09, 6'h0a, 6'h0b, 6'h0c, 6'h0e, 6'h10, 6'h11, 6'h13, 6'h14};
    localparam logic [15:0] RMSK [11] = '{16'hff00, 16'h4800, 16'h1000, 16'h0f80, 16'h0ff0, 16'h0fff, 16'h0070,
                                          16'h01ff, 16'h01ff, 16'h00ff, 16'h3c00};
    localparam logic [15:0] RFIX [11] = '{16'h0043, 16'h2000, 16'h0604, 16'h1058, 16'h0008, 16'h5000, 16'h1e00,
                                          16'h0000, 16'h0000, 16'h2700, 16'hc048};
    localparam logic [15:0] RRST [11] = '{16'h0a43, 16'h2000, 16'h0604, 16'h10d8, 16'h0018, 16'h5001, 16'h1e70,
                                          16'h0080, 16'h00fa, 16'h27b7, 16'hf848};
    logic        sys_clk = 1'b0, rst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_o, r;
    logic        wb_ack_o, wb_err_o, ref_doubler_en, ref_ref_multiplier_sel_valid, pump_current_valid, cal_busy, e;
    logic [2:0]  ref_ref_multiplier_sel_factor, vco_core, cs;
    logic [7:0]  ref_post_div, vco_band, fb;
    logic [11:0] ref_pre_div;
    logic [3:0]  pump_current_ma;
    logic [8:0]  vco_amp, sa, fa;
    logic [15:0] mdl [11];
    int          err_count = 0, total_checks = 0, seed = 32'he8e6, n;
    always #50 sys_clk = ~sys_clk;
    synth_cfg_regs i_dut (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .ref_doubler_en(ref_doubler_en), .ref_ref_multiplier_sel_factor(ref_ref_multiplier_sel_factor),
        .ref_ref_multiplier_sel_valid(ref_ref_multiplier_sel_valid), .ref_post_div(ref_post_div), .ref_pre_div(ref_pre_div),
        .pump_current_ma(pump_current_ma), .pump_current_valid(pump_current_valid), .cal_busy(cal_busy),
        .vco_amp(vco_amp), .vco_band(vco_band), .vco_core(vco_core));
    // ------------------------------------------------------------
    // Checking and bus helpers
    // ------------------------------------------------------------
    task automatic conclude();
        $display("checks=%0d errors=%0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        total_checks++;
        if (g !== x) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task automatic wb(input logic w, input logic [5:0] i, input logic [15:0] d, input logic [3:0] s);
        int k;
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= w; wb_adr_i <= {i, 2'b00};
        wb_dat_i <= {16'h0000, d}; wb_sel_i <= s;
        // Ack comes one cycle after the take; the bound only guards a hang
        for (k = 0; k < 50; k++) begin
            @(posedge sys_clk);
            if (wb_ack_o === 1'b1 || wb_err_o === 1'b1) break;
        end
        r = wb_dat_o; e = wb_err_o;
        wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0;
        if (k == 50) begin err_count++; conclude(); end
    endtask
    task automatic wr(input int k, input logic [15:0] d);
        logic [15:0] v;
        v = (d & RMSK[k]) | RFIX[k];
        if (k == 0 && v[15:8] < RST_AMP_DELAY) v[15:8] = RST_AMP_DELAY;
        wb(1'b1, RIDX[k], v, 4'hf);
        mdl[k] = v;
    endtask
    function automatic logic [3:0] ref_multiplier_sel_exp(input logic [4:0] c);
        return (c == 5'h01 || c == 5'h03 || c == 5'h07) ? {1'b1, c[2:0]} : 4'h0;
    endfunction
    function automatic logic [4:0] pump_exp(input logic [2:0] c);
        case (c)
            3'h0: return 5'h10;
            3'h1: return 5'h16;
            3'h3: return 5'h1c;
            3'h4: return 5'h13;
            3'h5: return 5'h19;
            3'h7: return 5'h1f;
            default: return 5'h00;
        endcase
    endfunction
    task automatic check_all();
        chk(32'(ref_doubler_en), 32'(mdl[2][12]));
        chk(32'({ref_ref_multiplier_sel_valid, ref_ref_multiplier_sel_valid ? ref_ref_multiplier_sel_factor : 3'h0}), 32'(ref_multiplier_sel_exp(mdl[3][11:7])));
        chk(32'(ref_post_div), 32'(mdl[4][11:4]));
        chk(32'(ref_pre_div), 32'(mdl[5][11:0]));
        chk(32'({pump_current_valid, pump_current_valid ? pump_current_ma : 4'h0}), 32'(pump_exp(mdl[6][6:4])));
        for (int k = 0; k < 11; k++) begin
            wb(1'b0, RIDX[k], 16'h0000, 4'hf);
            chk(r, {16'h0000, mdl[k]});
        end
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        mdl = RRST;
        check_all();
        chk(32'({vco_amp, vco_band, vco_core}), 32'({9'h0fa, 8'hb7, 3'h7}));
        $display("test reset done");
        repeat (3) for (int k = 0; k < 11; k++) wr(k, 16'($random(seed)));
        check_all();
        wb(1'b1, 6'h09, 16'hffff, 4'h1);
        chk(32'(e), 32'h0000_0001);
        wb(1'b0, 6'h03, 16'h0000, 4'hf);
        chk(32'(e), 32'h0000_0001);
        check_all();
        $display("test random writes done");
        for (int c = 0; c < 32; c++) begin
            wr(3, RFIX[3] | 16'(c << 7));
            check_all();
        end
        for (int c = 0; c < 8; c++) begin
            wr(6, RFIX[6] | 16'(c << 4));
            check_all();
        end
        $display("test code tables done");
        for (int p = 0; p < 2; p++) begin
            sa = 9'($random(seed)) | 9'h010; fa = 9'($random(seed)); fb = 8'($random(seed));
            cs = 3'($random(seed)) | 3'h1;
            wr(0, p ? 16'h1943 : 16'h0a43);
            wb(1'b1, 6'h01, 16'h0008, 4'hf);
            wr(8, {7'h00, sa});
            wr(7, {7'h00, fa});
            wr(9, {8'h27, fb});
            wr(10, 16'hc048 | {2'h0, cs, 1'(p), 10'h000});
            wr(1, 16'h2000 | {1'h0, 1'(p), 2'h0, 1'(p), 11'h000});
            wb(1'b1, 6'h00, 16'h0008, 4'hf);
            for (n = 0; n < 20 && cal_busy !== 1'b1; n++) @(posedge sys_clk);
            for (n = 0; n < 20000 && cal_busy !== 1'b0; n++) @(posedge sys_clk);
            if (n == 20000) begin err_count++; conclude(); end
            chk(32'(vco_amp), p ? 32'(fa) : 32'(sa - 9'(AMP_STEPS)));
            chk(32'(vco_core), 32'(cs));
            if (p == 1) chk(32'({vco_band, vco_core}), 32'({fb, cs}));
            wb(1'b0, IDX_CAL_STATUS, 16'h0000, 4'hf);
            chk(r, 32'h0000_0002);
            $display("test calibration pass %0d done", p);
        end
        conclude();
    end
endmodule
